// File: crf_pkg.sv
// Package with register indices, widths, reset values and access types of the core register file.
package crf_pkg;

  // ----------------------------------------------------------------------
  // Register indices on the datapath port and on the bus
  // ----------------------------------------------------------------------
  localparam logic [3:0] IDX_DATA0 = 4'h0;
  localparam logic [3:0] IDX_DATA1 = 4'h1;
  localparam logic [3:0] IDX_DATA2 = 4'h2;
  localparam logic [3:0] IDX_DATA3 = 4'h3;
  localparam logic [3:0] IDX_ADDR0 = 4'h4;
  localparam logic [3:0] IDX_ADDR1 = 4'h5;
  localparam logic [3:0] IDX_FRAME = 4'h6;
  localparam logic [3:0] IDX_VTB = 4'h7;
  localparam logic [3:0] IDX_PC = 4'h8;
  localparam logic [3:0] IDX_USP = 4'h9;
  localparam logic [3:0] IDX_ISP = 4'ha;
  localparam logic [3:0] IDX_SB = 4'hb;
  localparam logic [3:0] IDX_FLAG = 4'hc;
  localparam int NUM_REGS = 13;

  // ----------------------------------------------------------------------
  // Widths, field positions and reset values
  // ----------------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int LONG_W = 20;
  localparam int BYTE_W = 8;
  localparam int STACK_SEL_BIT = 7;
  localparam int SW_INT_LIMIT = 32;
  localparam logic [19:0] RST_LONG = 20'h00000;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_FLAG = 16'h0000;
  localparam logic [15:0] FLAG_MASK = 16'h07ff;
  localparam logic [31:0] WB_UNMAPPED = 32'h00000000;

  // ----------------------------------------------------------------------
  // Access kinds used by the datapath write port
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CRF_ACC_WORD = 2'h0,
    CRF_ACC_LOW = 2'h1,
    CRF_ACC_HIGH = 2'h3,
    CRF_ACC_PAIR = 2'h2
  } crf_acc_t;

  // Selector of a joined 32-bit pair.
  typedef enum logic [1:0] {
    CRF_PAIR_DATA_LOW = 2'h0,
    CRF_PAIR_DATA_HIGH = 2'h1,
    CRF_PAIR_ADDR = 2'h3
  } crf_pair_t;

  // Datapath write request.
  typedef struct packed {
    logic we;
    crf_acc_t acc;
    logic [3:0] idx;
    crf_pair_t pair;
    logic [31:0] data;
  } crf_wr_t;

  // Datapath control events.
  typedef struct packed {
    logic hw_int_ack;
    logic sw_int_exec;
    logic [5:0] sw_int_num;
    logic push;
    logic pop;
  } crf_evt_t;

  // Wishbone bus slave state.
  typedef enum logic [1:0] {
    CRF_BUS_IDLE = 2'h0,
    CRF_BUS_ACK = 2'h1
  } crf_bus_t;

endpackage

// File: crf_core_regs.sv
// Programmer-visible register set of a small 16-bit core with datapath and Wishbone ports.
`timescale 1ns/1ps
// Behaviour
// - Four 16-bit data registers for transfer, arithmetic and logic work.
// - Data zero and one split into high and low bytes written independently.
// - Data two with zero, data three with one form two 32-bit registers.
// - Two 16-bit address registers serve as bases and as operands.
// - Address registers join into one 32-bit register written at once.
// - A 16-bit frame base register is held.
// - A 20-bit vector table base register is held.
// - Separate 16-bit user and interrupt stack pointers are held.
// - A 16-bit static base register is held.
// - Low external reset initialises all core state.
// - Select bit zero picks interrupt pointer, one picks user pointer.
// - Hardware interrupt ack or software interrupt 0..31 clears select bit.
module crf_core_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire crf_pkg::crf_wr_t wr,
  input wire crf_pkg::crf_evt_t evt,
  input wire logic [19:0] pc_next,
  input wire logic pc_load,
  input wire logic [3:0] rd_idx,
  input wire crf_pkg::crf_pair_t rd_pair,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [19:0] rd_data,
  output logic [31:0] rd_pair_data,
  output logic [15:0] stack_ptr,
  output logic stack_sel,
  output logic [19:0] pc_out
);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [19:0] regs_ff [crf_pkg::NUM_REGS];
  logic [19:0] nxt_regs [crf_pkg::NUM_REGS];
  crf_pkg::crf_bus_t bus_ff;
  crf_pkg::crf_bus_t nxt_bus;
  logic [31:0] wb_dat_ff;
  logic [19:0] rd_data_ff;
  logic [31:0] rd_pair_ff;
  logic [15:0] sp_ff;
  logic sel_ff;
  logic ack_ff;

  // The one storage array holds every programmer-visible register of the core.
  // Entries 0..3 are the 16-bit data words.
  // Entries 4 and 5 are the 16-bit address words.
  // Entry 6 is the frame base and entry 11 the static base.
  // Entry 7 is the 20-bit vector table base, kept at full width.
  // Entries 9 and 10 are the user and interrupt stack pointers.

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire logic [3:0] bus_idx = wb_adr_i[5:2];
  wire logic bus_hit = (bus_idx < 4'(crf_pkg::NUM_REGS));
  wire logic bus_req = wb_cyc_i && wb_stb_i && (bus_ff == crf_pkg::CRF_BUS_IDLE);
  wire logic bus_wr = bus_req && wb_we_i && bus_hit;
  wire logic [19:0] bus_cur = bus_hit ? regs_ff[bus_idx] : 20'h00000;
  // Byte lanes: lanes 0..2 cover the 20-bit word, lane 3 reads as zero.
  wire logic [19:0] bus_mask = {{4{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [19:0] bus_val = (bus_cur & ~bus_mask) | (wb_dat_i[19:0] & bus_mask);

  // Stack select bit and the active pointer.
  wire logic cur_sel = regs_ff[crf_pkg::IDX_FLAG][crf_pkg::STACK_SEL_BIT];
  wire logic [3:0] sp_idx = cur_sel ? crf_pkg::IDX_USP : crf_pkg::IDX_ISP;
  wire logic sw_low = evt.sw_int_exec && (evt.sw_int_num < 6'(crf_pkg::SW_INT_LIMIT));
  wire logic sel_clr = evt.hw_int_ack || sw_low;

  // Pair read: first-named register forms the upper half.
  wire logic [31:0] pair_rd =
    (rd_pair == crf_pkg::CRF_PAIR_DATA_LOW) ?
      {regs_ff[crf_pkg::IDX_DATA2][15:0], regs_ff[crf_pkg::IDX_DATA0][15:0]} :
    (rd_pair == crf_pkg::CRF_PAIR_DATA_HIGH) ?
      {regs_ff[crf_pkg::IDX_DATA3][15:0], regs_ff[crf_pkg::IDX_DATA1][15:0]} :
      {regs_ff[crf_pkg::IDX_ADDR1][15:0], regs_ff[crf_pkg::IDX_ADDR0][15:0]};

  // Pair write targets.
  wire logic [3:0] pair_hi =
    (wr.pair == crf_pkg::CRF_PAIR_DATA_LOW) ? crf_pkg::IDX_DATA2 :
    (wr.pair == crf_pkg::CRF_PAIR_DATA_HIGH) ? crf_pkg::IDX_DATA3 : crf_pkg::IDX_ADDR1;
  wire logic [3:0] pair_lo =
    (wr.pair == crf_pkg::CRF_PAIR_DATA_LOW) ? crf_pkg::IDX_DATA0 :
    (wr.pair == crf_pkg::CRF_PAIR_DATA_HIGH) ? crf_pkg::IDX_DATA1 : crf_pkg::IDX_ADDR0;
  wire logic pair_wr = wr.we && (wr.acc == crf_pkg::CRF_ACC_PAIR);
  wire logic byte_ok = (wr.idx == crf_pkg::IDX_DATA0) || (wr.idx == crf_pkg::IDX_DATA1);

  // ----------------------------------------------------------------------
  // Next value per register, one generate entry each
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < crf_pkg::NUM_REGS; g++) begin : g_reg
    localparam logic [3:0] GI = 4'(g);
    localparam logic [19:0] WMASK = (GI == crf_pkg::IDX_VTB || GI == crf_pkg::IDX_PC) ?
      20'hfffff : ((GI == crf_pkg::IDX_FLAG) ? {4'h0, crf_pkg::FLAG_MASK} : 20'h0ffff);
    always_comb begin
      nxt_regs[g] = regs_ff[g];
      if (bus_wr && bus_idx == GI) begin
        nxt_regs[g] = bus_val & WMASK;
      end
      if (wr.we && wr.idx == GI && wr.acc == crf_pkg::CRF_ACC_WORD) begin
        nxt_regs[g] = wr.data[19:0] & WMASK;
      end
      if (wr.we && byte_ok && wr.idx == GI && wr.acc == crf_pkg::CRF_ACC_LOW) begin
        nxt_regs[g][7:0] = wr.data[7:0];
      end
      if (wr.we && byte_ok && wr.idx == GI && wr.acc == crf_pkg::CRF_ACC_HIGH) begin
        nxt_regs[g][15:8] = wr.data[7:0];
      end
      if (pair_wr && pair_hi == GI) begin
        nxt_regs[g] = {4'h0, wr.data[31:16]};
      end
      if (pair_wr && pair_lo == GI) begin
        nxt_regs[g] = {4'h0, wr.data[15:0]};
      end
      if (GI == crf_pkg::IDX_PC && pc_load) begin
        nxt_regs[g] = pc_next;
      end
      if (GI == sp_idx && evt.push) begin
        nxt_regs[g] = {4'h0, regs_ff[g][15:0] - 16'h0002};
      end
      if (GI == sp_idx && evt.pop && !evt.push) begin
        nxt_regs[g] = {4'h0, regs_ff[g][15:0] + 16'h0002};
      end
      if (GI == crf_pkg::IDX_FLAG && sel_clr) begin
        nxt_regs[g][crf_pkg::STACK_SEL_BIT] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bus answer and read paths
  // ----------------------------------------------------------------------
  assign nxt_bus = bus_req ? crf_pkg::CRF_BUS_ACK : crf_pkg::CRF_BUS_IDLE;
  // Read data is loaded only when a request is taken, so it stands until the next one.
  wire logic [31:0] nxt_wb_dat = !bus_req ? wb_dat_ff :
                                 bus_hit ? {12'h000, bus_cur} : crf_pkg::WB_UNMAPPED;
  wire logic [19:0] nxt_rd_data = (rd_idx < 4'(crf_pkg::NUM_REGS)) ? regs_ff[rd_idx] : 20'h00000;
  wire logic nxt_sel = nxt_regs[crf_pkg::IDX_FLAG][crf_pkg::STACK_SEL_BIT];
  wire logic [15:0] nxt_sp = nxt_sel ? nxt_regs[crf_pkg::IDX_USP][15:0] :
                                       nxt_regs[crf_pkg::IDX_ISP][15:0];

  // Registers, all cleared by the asynchronous reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < crf_pkg::NUM_REGS; i++) begin
        regs_ff[i] <= crf_pkg::RST_LONG;
      end
    end else begin
      for (int i = 0; i < crf_pkg::NUM_REGS; i++) begin
        regs_ff[i] <= nxt_regs[i];
      end
    end
  end

  // Output flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ff <= crf_pkg::CRF_BUS_IDLE;
      wb_dat_ff <= 32'h00000000;
      rd_data_ff <= crf_pkg::RST_LONG;
      rd_pair_ff <= 32'h00000000;
      sp_ff <= crf_pkg::RST_WORD;
      sel_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else begin
      bus_ff <= nxt_bus;
      ack_ff <= (nxt_bus == crf_pkg::CRF_BUS_ACK);
      wb_dat_ff <= nxt_wb_dat;
      rd_data_ff <= nxt_rd_data;
      rd_pair_ff <= pair_rd;
      sp_ff <= nxt_sp;
      sel_ff <= nxt_sel;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign rd_data = rd_data_ff;
  assign rd_pair_data = rd_pair_ff;
  assign stack_ptr = sp_ff;
  assign stack_sel = sel_ff;
  assign pc_out = regs_ff[crf_pkg::IDX_PC];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_word_write;
    @(posedge clk) disable iff (!rst_n)
      (wr.we && wr.acc == crf_pkg::CRF_ACC_WORD && wr.idx == crf_pkg::IDX_DATA1 && !pc_load
       && !(bus_wr && bus_idx == crf_pkg::IDX_DATA1))
      |=> regs_ff[crf_pkg::IDX_DATA1][15:0] == $past(wr.data[15:0]);
  endproperty
  a_word_write: assert property (p_word_write) else $error("Word write lost.");

  property p_low_byte;
    @(posedge clk) disable iff (!rst_n)
      (wr.we && wr.acc == crf_pkg::CRF_ACC_LOW && wr.idx == crf_pkg::IDX_DATA0 && !bus_wr)
      |=> regs_ff[crf_pkg::IDX_DATA0][15:8] == $past(regs_ff[crf_pkg::IDX_DATA0][15:8]);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("Low byte write hit high byte.");

  property p_pair_write;
    @(posedge clk) disable iff (!rst_n)
      (pair_wr && wr.pair == crf_pkg::CRF_PAIR_ADDR && !bus_wr)
      |=> {regs_ff[crf_pkg::IDX_ADDR1][15:0], regs_ff[crf_pkg::IDX_ADDR0][15:0]}
          == $past(wr.data);
  endproperty
  a_pair_write: assert property (p_pair_write) else $error("Address pair split.");

  property p_data_pair;
    @(posedge clk) disable iff (!rst_n)
      (rd_pair == crf_pkg::CRF_PAIR_DATA_LOW)
      |=> rd_pair_data[31:16] == $past(regs_ff[crf_pkg::IDX_DATA2][15:0]);
  endproperty
  a_data_pair: assert property (p_data_pair) else $error("Pair upper half wrong.");

  property p_pc_load;
    @(posedge clk) disable iff (!rst_n) pc_load |=> pc_out == $past(pc_next);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("Program counter not loaded.");

  property p_sel_clear;
    @(posedge clk) disable iff (!rst_n) sel_clr |=> !stack_sel;
  endproperty
  a_sel_clear: assert property (p_sel_clear) else $error("Stack select not cleared.");

  property p_sp_pick;
    @(posedge clk) disable iff (!rst_n)
      ##1 stack_ptr == (stack_sel ? regs_ff[crf_pkg::IDX_USP][15:0]
                                  : regs_ff[crf_pkg::IDX_ISP][15:0]);
  endproperty
  a_sp_pick: assert property (p_sp_pick) else $error("Wrong stack pointer shown.");

  property p_wb_ack;
    @(posedge clk) disable iff (!rst_n) bus_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("Bus answer not one cycle.");

  property p_frame_hold;
    @(posedge clk) disable iff (!rst_n)
      !(wr.we && wr.idx == crf_pkg::IDX_FRAME) && !(bus_wr && bus_idx == crf_pkg::IDX_FRAME)
      |=> $stable(regs_ff[crf_pkg::IDX_FRAME]);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("Frame base changed.");

  // A high byte write leaves the low byte of data word one alone.
  property p_high_byte;
    @(posedge clk) disable iff (!rst_n)
      (wr.we && wr.acc == crf_pkg::CRF_ACC_HIGH && wr.idx == crf_pkg::IDX_DATA1 && !bus_wr)
      |=> regs_ff[crf_pkg::IDX_DATA1][7:0] == $past(regs_ff[crf_pkg::IDX_DATA1][7:0]);
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("High byte write hit low byte.");

  // A high byte write lands in bits 15..8.
  property p_high_lands;
    @(posedge clk) disable iff (!rst_n)
      (wr.we && wr.acc == crf_pkg::CRF_ACC_HIGH && wr.idx == crf_pkg::IDX_DATA1 && !bus_wr)
      |=> regs_ff[crf_pkg::IDX_DATA1][15:8] == $past(wr.data[7:0]);
  endproperty
  a_high_lands: assert property (p_high_lands) else $error("High byte not written.");

  // The low data pair takes the whole 32-bit value at once.
  property p_pair_low;
    @(posedge clk) disable iff (!rst_n)
      (pair_wr && wr.pair == crf_pkg::CRF_PAIR_DATA_LOW && !bus_wr)
      |=> {regs_ff[crf_pkg::IDX_DATA2][15:0], regs_ff[crf_pkg::IDX_DATA0][15:0]}
          == $past(wr.data);
  endproperty
  a_pair_low: assert property (p_pair_low) else $error("Low data pair split.");

  // The high data pair takes the whole 32-bit value at once.
  property p_pair_high;
    @(posedge clk) disable iff (!rst_n)
      (pair_wr && wr.pair == crf_pkg::CRF_PAIR_DATA_HIGH && !bus_wr)
      |=> {regs_ff[crf_pkg::IDX_DATA3][15:0], regs_ff[crf_pkg::IDX_DATA1][15:0]}
          == $past(wr.data);
  endproperty
  a_pair_high: assert property (p_pair_high) else $error("High data pair split.");

  // The vector table base moves only when it is written.
  property p_vtb_hold;
    @(posedge clk) disable iff (!rst_n)
      !(wr.we && wr.idx == crf_pkg::IDX_VTB) && !(bus_wr && bus_idx == crf_pkg::IDX_VTB)
      |=> $stable(regs_ff[crf_pkg::IDX_VTB]);
  endproperty
  a_vtb_hold: assert property (p_vtb_hold) else $error("Vector base changed.");

  // The static base moves only when it is written.
  property p_sb_hold;
    @(posedge clk) disable iff (!rst_n)
      !(wr.we && wr.idx == crf_pkg::IDX_SB) && !(bus_wr && bus_idx == crf_pkg::IDX_SB)
      |=> $stable(regs_ff[crf_pkg::IDX_SB]);
  endproperty
  a_sb_hold: assert property (p_sb_hold) else $error("Static base changed.");

  // A push on the user pointer leaves the interrupt pointer alone.
  property p_isp_kept;
    @(posedge clk) disable iff (!rst_n)
      (evt.push && cur_sel && !(bus_wr && bus_idx == crf_pkg::IDX_ISP)
       && !(wr.we && wr.idx == crf_pkg::IDX_ISP))
      |=> $stable(regs_ff[crf_pkg::IDX_ISP]);
  endproperty
  a_isp_kept: assert property (p_isp_kept) else $error("Idle stack pointer moved.");

  // A push steps the chosen user pointer down by one word.
  property p_push_step;
    @(posedge clk) disable iff (!rst_n)
      (evt.push && cur_sel)
      |=> regs_ff[crf_pkg::IDX_USP][15:0] == $past(regs_ff[crf_pkg::IDX_USP][15:0]) - 16'h0002;
  endproperty
  a_push_step: assert property (p_push_step) else $error("Push missed user pointer.");

  // With the select bit set the user pointer is the one shown.
  property p_usp_pick;
    @(posedge clk) disable iff (!rst_n)
      stack_sel |-> stack_ptr == regs_ff[crf_pkg::IDX_USP][15:0];
  endproperty
  a_usp_pick: assert property (p_usp_pick) else $error("User pointer not shown.");

  // At the first edge after reset the program counter, bus answer, stack pointer and select still show their reset values.
  property p_reset_state;
    @(posedge clk)
      $rose(rst_n) |-> (pc_out == crf_pkg::RST_LONG && !wb_ack_o
                        && stack_ptr == crf_pkg::RST_WORD && !stack_sel);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("State not reset.");

  // No answer appears without a request on the cycle before.
  property p_ack_idle;
    @(posedge clk) disable iff (!rst_n)
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("Bus answer without request.");

  c_byte_write: cover property (@(posedge clk) disable iff (!rst_n)
    wr.we && wr.acc == crf_pkg::CRF_ACC_HIGH);
  c_pair_write: cover property (@(posedge clk) disable iff (!rst_n) pair_wr);
  c_irq_ack: cover property (@(posedge clk) disable iff (!rst_n) stack_sel ##1 sel_clr);
  c_bus_read: cover property (@(posedge clk) disable iff (!rst_n) bus_req && !wb_we_i);

endmodule // crf_core_regs

// File: crf_dp_model.sv
// Behavioural model of the instruction datapath that drives the register file.
`timescale 1ns/1ps
module crf_dp_model (
  input wire logic clk,
  output crf_pkg::crf_wr_t wr,
  output crf_pkg::crf_evt_t evt,
  output logic [19:0] pc_next,
  output logic pc_load,
  output logic [3:0] rd_idx,
  output crf_pkg::crf_pair_t rd_pair
);
  // Quiet values at time zero.
  initial begin
    wr = '0;
    evt = '0;
    pc_next = 20'h0;
    pc_load = 1'b0;
    rd_idx = 4'h0;
    rd_pair = crf_pkg::CRF_PAIR_DATA_LOW;
  end

  // One write pulse; released data lines show the inverse so stale values never match.
  task automatic wrt(input crf_pkg::crf_acc_t a, input logic [3:0] i,
                     input crf_pkg::crf_pair_t p, input logic [31:0] d);
    @(posedge clk);
    wr <= '{we: 1'b1, acc: a, idx: i, pair: p, data: d};
    @(posedge clk);
    wr.we <= 1'b0;
    wr.data <= ~d;
  endtask

  // One event and program counter pulse.
  task automatic pulse(input crf_pkg::crf_evt_t e, input logic pl, input logic [19:0] pv);
    @(posedge clk);
    evt <= e;
    pc_load <= pl;
    pc_next <= pv;
    @(posedge clk);
    evt <= '0;
    pc_load <= 1'b0;
    pc_next <= ~pv;
  endtask

  // Read selects are levels.
  task automatic sel(input logic [3:0] i, input crf_pkg::crf_pair_t p);
    @(posedge clk);
    rd_idx <= i;
    rd_pair <= p;
  endtask
endmodule // crf_dp_model

// File: crf_core_regs_test.sv
// Self-checking testbench of the core register file.
`timescale 1ns/1ps
module crf_core_regs_test;
  logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pc_load, stack_sel;
  logic [5:0] wb_adr_i;
  logic [3:0] wb_sel_i, rd_idx;
  logic [31:0] wb_dat_i, wb_dat_o, rd_pair_data, r;
  logic [19:0] rd_data, pc_out, pc_next;
  logic [15:0] stack_ptr;
  crf_pkg::crf_wr_t wr;
  crf_pkg::crf_evt_t evt;
  crf_pkg::crf_pair_t rd_pair;
  crf_pkg::crf_pair_t pr[3] = '{crf_pkg::CRF_PAIR_DATA_LOW, crf_pkg::CRF_PAIR_DATA_HIGH,
                                crf_pkg::CRF_PAIR_ADDR};
  int hi[3] = '{2, 3, 5};
  int lo[3] = '{0, 1, 4};
  logic [31:0] exp_q[$];
  logic [31:0] val[16];
  int err_count, checked;

  crf_core_regs dut_u (.clk(clk), .rst_n(rst_n), .wr(wr), .evt(evt), .pc_next(pc_next),
    .pc_load(pc_load), .rd_idx(rd_idx), .rd_pair(rd_pair), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rd_data(rd_data),
    .rd_pair_data(rd_pair_data), .stack_ptr(stack_ptr), .stack_sel(stack_sel),
    .pc_out(pc_out));
  crf_dp_model dp_u (.clk(clk), .wr(wr), .evt(evt), .pc_next(pc_next), .pc_load(pc_load),
    .rd_idx(rd_idx), .rd_pair(rd_pair));

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One classic cycle; the request holds until ack is sampled high.
  task automatic bus(input logic we, input int i, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {i[3:0], 2'b00};
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    check(32'(wb_ack_o), 32'h1, "wb_ack_o");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= ~d;
    @(posedge clk);
  endtask

  task automatic rd(input int i, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, i, 32'h0);
  endtask

  task automatic stk(input crf_pkg::crf_evt_t e, input logic s, input logic [31:0] p);
    dp_u.pulse(e, 1'b0, 20'h0);
    @(negedge clk);
    check(32'(stack_sel), 32'(s), "stack_sel");
    check(32'(stack_ptr), p & 32'h0000ffff, "stack_ptr");
  endtask

  function automatic logic [31:0] mask(input int i);
    if (i == 7 || i == 8) return 32'h000fffff;
    if (i == 12) return {16'h0, crf_pkg::FLAG_MASK};
    return 32'h0000ffff;
  endfunction

  // Read data is compared with the oldest note when ack appears.
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      check(wb_dat_o, exp_q.pop_front(), "wb_dat_o");
    end
  end

  // ----------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cuts a hang well past the expected run of a few hundred cycles.
  initial begin
    #(100 * 20000);
    err_count++;
    finish_test();
  end

  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    void'($urandom(85));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 14; i++) rd(i, 32'h0);
    for (int i = 0; i < 13; i++) begin
      r = $urandom();
      val[i] = r & mask(i);
      bus(1'b1, i, r);
    end
    bus(1'b1, 14, 32'hffffffff);
    for (int i = 0; i < 15; i++) rd(i, (i < 13) ? val[i] : 32'h0);
    for (int k = 0; k < 3; k++) begin
      r = $urandom();
      dp_u.wrt(crf_pkg::CRF_ACC_PAIR, 4'h0, pr[k], r);
      val[hi[k]] = {16'h0, r[31:16]};
      val[lo[k]] = {16'h0, r[15:0]};
      dp_u.sel(4'h8, pr[k]);
      repeat (2) @(negedge clk);
      check(rd_pair_data, r, "rd_pair_data");
    end
    dp_u.wrt(crf_pkg::CRF_ACC_LOW, 4'h0, pr[0], 32'h00005a5a);
    dp_u.wrt(crf_pkg::CRF_ACC_HIGH, 4'h1, pr[0], 32'h0000a5a5);
    dp_u.wrt(crf_pkg::CRF_ACC_LOW, 4'h2, pr[0], 32'h00003c3c);
    val[0][7:0] = 8'h5a;
    val[1][15:8] = 8'ha5;
    for (int i = 0; i < 6; i++) rd(i, val[i]);
    r = $urandom() & 32'h000fffff;
    dp_u.pulse('0, 1'b1, r[19:0]);
    @(negedge clk);
    check(32'(pc_out), r, "pc_out");
    @(negedge clk);
    check(32'(rd_data), r, "rd_data");
    bus(1'b1, 12, 32'h80);
    stk(10'h002, 1'b1, val[9] - 32'h2);
    stk(10'h180, 1'b1, val[9] - 32'h2);
    stk(10'h17c, 1'b0, val[10]);
    stk(10'h001, 1'b0, val[10] + 32'h2);
    bus(1'b1, 12, 32'h80);
    stk(10'h200, 1'b0, val[10] + 32'h2);
    rd(12, 32'h0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 13; i++) rd(i, 32'h0);
    check(32'(exp_q.size()), 32'h0, "pending reads");
    finish_test();
  end
endmodule // crf_core_regs_test
